// *** core/glass_clock_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module glass_clock_gen (
    input wire logic mclk,
    input wire logic rst,
    input wire logic src_tick,
    input wire lcd_timing_pkg::prescale_cfg_t cfg,
    output logic ps_tick
);
    import lcd_timing_pkg::*;

    logic [11:0] pre_cnt_r;
    logic [2:0] div_cnt_r;
    logic [12:0] n_val;
    logic tap_hit;

    assign n_val = tap_divisor(cfg.tap_sel);
    assign tap_hit = src_tick &&
        ((pre_cnt_r & 12'(n_val - 13'h0001)) == 12'(n_val - 13'h0001));

    always_ff @(posedge mclk) begin
        if (rst) begin
            pre_cnt_r <= 12'h000;
        end else if (src_tick) begin
            pre_cnt_r <= pre_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_cnt_r <= 3'h0;
            ps_tick <= 1'b0;
        end else begin
            ps_tick <= 1'b0;
            if (tap_hit) begin
                if (div_cnt_r >= cfg.div_sel) begin
                    div_cnt_r <= 3'h0;
                    ps_tick <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 3'h1;
                end
            end
        end
    end

    property p_tap_aligned;
        @(posedge mclk) disable iff (rst)
        tap_hit |-> (pre_cnt_r[3:0] == 4'hF);
    endproperty
    a_tap_aligned: assert property (p_tap_aligned)
        else $error("prescaler tap fired off its boundary");

    property p_div_count;
        @(posedge mclk) disable iff (rst)
        (tap_hit && div_cnt_r == cfg.div_sel) |=> ps_tick;
    endproperty
    a_div_count: assert property (p_div_count)
        else $error("divider did not emit tick at divide count");

endmodule
`default_nettype wire

// *** core/lcd_frame_timing.sv ***
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Prescaled clock is prescaler tap output further divided by D; runs the module.
// - Tap code 0..7 picks N of 16,64,128,256,512,1024,2048,4096.
// - Divide field gives D equal to field value plus one.
// - Frame rate is source clock over K*N*D; K is 6 for 1/3 duty.
// - Drive field picks 300,70,150,450,575,850,1150 us or half a period.
// - Driver on-time never exceeds half a prescaled clock period.
// - Static duty or blanking forces on-time of half a prescaled period.
// - A drive field write acts at once, not at a frame boundary.
// - Frame-rate bits 7 and 3 and contrast bit 4 read as zero.
// - Source clock is system clock when select is 0, external when 1.
// - Duty codes 00..11 give static, 1/2, 1/3, 1/4 and set K.
// - Blanking takes effect when the current frame completes.
module lcd_frame_timing #(
    parameter int unsigned CYCLES_PER_US_P = lcd_timing_pkg::CYCLES_PER_US
) (
    input wire logic mclk,
    input wire logic rst,
    input wire lcd_timing_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk,
    output logic prescaled_glass_clock,
    output logic frame_start,
    output logic driver_on,
    output logic display_blank_active
);
    import lcd_timing_pkg::*;

    logic [7:0] frame_rate_r;
    logic [7:0] contrast_drive_r;
    logic [7:0] glass_ctrl_a_r;
    logic [7:0] glass_ctrl_b_r;
    logic [7:0] frame_cnt_r;
    logic [2:0] k_cnt_r;
    logic [15:0] half_cnt_r;
    logic [15:0] us_cnt_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic ext_lvl_r;
    logic ps_tick;
    logic src_tick;
    logic ext_rise;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [7:0] rd_byte;
    logic [2:0] drv_sel;
    logic [2:0] k_max;
    logic [15:0] nd_val;
    logic [15:0] half_val;
    logic [15:0] nom_cycles;
    logic half_only;
    logic half_hit;
    logic nom_hit;
    duty_t duty;
    prescale_cfg_t ps_cfg;

    // Bus decode: every transfer finishes in its first access cycle.
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && pready &&
        apb_req.pwrite;
    assign mapped = (apb_req.paddr == OFS_FRAME_RATE) ||
        (apb_req.paddr == OFS_CONTRAST_DRIVE) ||
        (apb_req.paddr == OFS_GLASS_CTRL_A) ||
        (apb_req.paddr == OFS_GLASS_CTRL_B) ||
        (apb_req.paddr == OFS_STATUS);

    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_rate_r <= REG_RESET;
            contrast_drive_r <= REG_RESET;
            glass_ctrl_a_r <= REG_RESET;
            glass_ctrl_b_r <= REG_RESET;
        end else if (wr_en && !pslverr) begin
            unique case (apb_req.paddr)
                OFS_FRAME_RATE: begin
                    frame_rate_r <= apb_req.pwdata[7:0] & FRAME_RATE_MASK;
                end
                OFS_CONTRAST_DRIVE: begin
                    contrast_drive_r <= apb_req.pwdata[7:0] &
                        CONTRAST_DRIVE_MASK;
                end
                OFS_GLASS_CTRL_A: begin
                    glass_ctrl_a_r <= apb_req.pwdata[7:0] &
                        GLASS_CTRL_A_MASK;
                end
                OFS_GLASS_CTRL_B: begin
                    glass_ctrl_b_r <= apb_req.pwdata[7:0] &
                        GLASS_CTRL_B_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (apb_req.paddr)
            OFS_FRAME_RATE: rd_byte = frame_rate_r;
            OFS_CONTRAST_DRIVE: rd_byte = contrast_drive_r;
            OFS_GLASS_CTRL_A: rd_byte = glass_ctrl_a_r;
            OFS_GLASS_CTRL_B: rd_byte = glass_ctrl_b_r;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            if (apb_req.paddr == OFS_STATUS) begin
                prdata <= {16'h0000, frame_cnt_r, 5'h00,
                    prescaled_glass_clock, display_blank_active, driver_on};
            end else begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // External clock: three stages, a rising edge counts when stages two and
    // three agree on the new level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            ext_lvl_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_s2_r == ext_s3_r) begin
                ext_lvl_r <= ext_s3_r;
            end
        end
    end

    assign ext_rise = ext_s2_r && ext_s3_r && !ext_lvl_r;
    assign src_tick = glass_ctrl_b_r[SRC_SEL_BIT] ? ext_rise : 1'b1;

    assign ps_cfg.tap_sel = frame_rate_r[TAP_LSB +: 3];
    assign ps_cfg.div_sel = frame_rate_r[DIV_LSB +: 3];

    glass_clock_gen u_glass_clock_gen (
        .mclk(mclk),
        .rst(rst),
        .src_tick(src_tick),
        .cfg(ps_cfg),
        .ps_tick(ps_tick)
    );

    // Period of the prescaled clock in source ticks is N*D.
    // D is formed at four bits so that divide code 7 gives 8, not 0.
    assign nd_val = 16'({3'h0, tap_divisor(ps_cfg.tap_sel)} *
        {12'h000, {1'b0, ps_cfg.div_sel} + 4'h1});
    assign half_val = {1'b0, nd_val[15:1]};
    assign half_hit = half_cnt_r >= half_val;

    always_ff @(posedge mclk) begin
        if (rst) begin
            half_cnt_r <= 16'h0000;
            prescaled_glass_clock <= 1'b0;
        end else if (ps_tick) begin
            // The tick's own source tick is the first of the half period,
            // so the high phase never outlasts half a period.
            half_cnt_r <= 16'h0001;
            prescaled_glass_clock <= 1'b1;
        end else begin
            if (src_tick && !half_hit) begin
                half_cnt_r <= half_cnt_r + 16'h0001;
            end
            if (half_hit) begin
                prescaled_glass_clock <= 1'b0;
            end
        end
    end

    // Frame sequencing.
    assign duty = duty_t'(glass_ctrl_b_r[DUTY_LSB +: 2]);
    always_comb begin
        unique case (duty)
            DUTY_THIRD: k_max = K_SIX;
            DUTY_STATIC, DUTY_HALF, DUTY_QUARTER: k_max = K_EIGHT;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            k_cnt_r <= 3'h0;
            frame_start <= 1'b0;
            frame_cnt_r <= 8'h00;
        end else begin
            frame_start <= 1'b0;
            if (ps_tick) begin
                if (k_cnt_r >= k_max) begin
                    k_cnt_r <= 3'h0;
                    frame_start <= 1'b1;
                    frame_cnt_r <= frame_cnt_r + 8'h01;
                end else begin
                    k_cnt_r <= k_cnt_r + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            display_blank_active <= 1'b0;
        end else if (frame_start) begin
            display_blank_active <= glass_ctrl_a_r[BLANK_BIT];
        end
    end

    // Driver on-time; the field is read live so a write acts at once.
    assign drv_sel = contrast_drive_r[DRV_LSB +: 3];
    assign half_only = (drv_sel == DRV_HALF_CODE) ||
        (duty == DUTY_STATIC) || display_blank_active;
    assign nom_cycles = 16'(drive_us(drv_sel) * CYCLES_PER_US_P);
    assign nom_hit = !half_only && (us_cnt_r >= nom_cycles);

    always_ff @(posedge mclk) begin
        if (rst) begin
            us_cnt_r <= 16'h0000;
        end else if (ps_tick) begin
            // The first on cycle counts as one, giving exactly the nominal
            // number of cycles.
            us_cnt_r <= 16'h0001;
        end else if (us_cnt_r != 16'hFFFF) begin
            us_cnt_r <= us_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            driver_on <= 1'b0;
        end else if (ps_tick) begin
            driver_on <= 1'b1;
        end else if (half_hit || nom_hit) begin
            driver_on <= 1'b0;
        end
    end

    // Checks.
    property p_tick_raises_clock;
        @(posedge mclk) disable iff (rst)
        ps_tick |=> prescaled_glass_clock && driver_on &&
            half_cnt_r == 16'h0001;
    endproperty
    a_tick_raises_clock: assert property (p_tick_raises_clock)
        else $error("prescaled clock did not start at tick");

    property p_frame_k;
        @(posedge mclk) disable iff (rst)
        frame_start |-> $past(ps_tick) && $past(k_cnt_r) >= k_max &&
            k_cnt_r == 3'h0;
    endproperty
    a_frame_k: assert property (p_frame_k)
        else $error("frame start not at K prescaled ticks");

    property p_nominal_off;
        @(posedge mclk) disable iff (rst)
        (driver_on && !half_only && us_cnt_r >= nom_cycles && !ps_tick)
            |=> !driver_on;
    endproperty
    a_nominal_off: assert property (p_nominal_off)
        else $error("driver stayed on past nominal time");

    property p_half_limit;
        @(posedge mclk) disable iff (rst)
        (half_hit && !ps_tick) |=> !driver_on && !prescaled_glass_clock;
    endproperty
    a_half_limit: assert property (p_half_limit)
        else $error("driver stayed on past half period");

    property p_half_only;
        @(posedge mclk) disable iff (rst)
        (half_only && driver_on && !ps_tick && !half_hit) |=>
            driver_on == prescaled_glass_clock;
    endproperty
    a_half_only: assert property (p_half_only)
        else $error("forced half-period drive time not kept");

    property p_drive_write_now;
        @(posedge mclk) disable iff (rst)
        (wr_en && !pslverr && apb_req.paddr == OFS_CONTRAST_DRIVE) |=>
            drv_sel == $past(apb_req.pwdata[DRV_LSB +: 3]);
    endproperty
    a_drive_write_now: assert property (p_drive_write_now)
        else $error("drive field write not applied at once");

    property p_reserved_zero;
        @(posedge mclk) disable iff (rst)
        (pready && !pslverr && apb_req.paddr == OFS_FRAME_RATE) |->
            prdata[7] == 1'b0 && prdata[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved frame-rate bit read as one");

    property p_sysclk_source;
        @(posedge mclk) disable iff (rst)
        !glass_ctrl_b_r[SRC_SEL_BIT] |-> src_tick;
    endproperty
    a_sysclk_source: assert property (p_sysclk_source)
        else $error("system clock not used as source");

    property p_third_duty_k;
        @(posedge mclk) disable iff (rst)
        (duty == DUTY_THIRD) |-> k_max == K_SIX;
    endproperty
    a_third_duty_k: assert property (p_third_duty_k)
        else $error("K not six for one-third duty");

    property p_blank_at_frame;
        @(posedge mclk) disable iff (rst)
        (frame_start && glass_ctrl_a_r[BLANK_BIT]) |=> display_blank_active;
    endproperty
    a_blank_at_frame: assert property (p_blank_at_frame)
        else $error("blanking not taken at frame completion");

    property p_frame_pulse;
        @(posedge mclk) disable iff (rst)
        frame_start |=> !frame_start;
    endproperty
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("frame start strobe longer than one cycle");

    c_frame: cover property (@(posedge mclk) disable iff (rst) frame_start);
    c_nominal: cover property (@(posedge mclk) disable iff (rst)
        driver_on && nom_hit);
    c_blank: cover property (@(posedge mclk) disable iff (rst)
        $rose(display_blank_active));
    c_ext: cover property (@(posedge mclk) disable iff (rst)
        glass_ctrl_b_r[SRC_SEL_BIT] && ps_tick);

endmodule
`default_nettype wire

// *** core/lcd_timing_pkg.sv ***
package lcd_timing_pkg;

    // Clock rate of mclk and the derived cycles per microsecond.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;
    localparam int unsigned CYCLES_PER_US = CLK_HZ / HZ_PER_MHZ;

    // Register byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_FRAME_RATE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTRAST_DRIVE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GLASS_CTRL_A = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GLASS_CTRL_B = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    // Field positions.
    localparam int TAP_LSB = 4;
    localparam int DIV_LSB = 0;
    localparam int DRV_LSB = 5;
    localparam int CONTRAST_LSB = 0;
    localparam int BLANK_BIT = 0;
    localparam int SRC_SEL_BIT = 7;
    localparam int DUTY_LSB = 4;
    localparam int ST_DRV_BIT = 0;
    localparam int ST_BLANK_BIT = 1;
    localparam int ST_GCLK_BIT = 2;
    localparam int ST_FRAME_LSB = 8;

    // Implemented bits of each register; all others read as zero.
    localparam logic [7:0] FRAME_RATE_MASK = 8'h77;
    localparam logic [7:0] CONTRAST_DRIVE_MASK = 8'hEF;
    localparam logic [7:0] GLASS_CTRL_A_MASK = 8'h01;
    localparam logic [7:0] GLASS_CTRL_B_MASK = 8'hB0;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        DUTY_STATIC = 2'b00,
        DUTY_HALF = 2'b01,
        DUTY_THIRD = 2'b10,
        DUTY_QUARTER = 2'b11
    } duty_t;

    // Last prescaled tick count of a frame (K minus one).
    localparam logic [2:0] K_EIGHT = 3'h7;
    localparam logic [2:0] K_SIX = 3'h5;

    // Driver on-time codes and nominal times in microseconds.
    localparam logic [2:0] DRV_HALF_CODE = 3'h7;
    localparam int unsigned DRV_US_0 = 300;
    localparam int unsigned DRV_US_1 = 70;
    localparam int unsigned DRV_US_2 = 150;
    localparam int unsigned DRV_US_3 = 450;
    localparam int unsigned DRV_US_4 = 575;
    localparam int unsigned DRV_US_5 = 850;
    localparam int unsigned DRV_US_6 = 1150;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [2:0] tap_sel;
        logic [2:0] div_sel;
    } prescale_cfg_t;

    function automatic int unsigned drive_us(input logic [2:0] code);
        case (code)
            3'h0: drive_us = DRV_US_0;
            3'h1: drive_us = DRV_US_1;
            3'h2: drive_us = DRV_US_2;
            3'h3: drive_us = DRV_US_3;
            3'h4: drive_us = DRV_US_4;
            3'h5: drive_us = DRV_US_5;
            default: drive_us = DRV_US_6;
        endcase
    endfunction

    // Source-clock divisor N of each tap code.
    function automatic logic [12:0] tap_divisor(input logic [2:0] code);
        case (code)
            3'h0: tap_divisor = 13'h0010;
            3'h1: tap_divisor = 13'h0040;
            3'h2: tap_divisor = 13'h0080;
            3'h3: tap_divisor = 13'h0100;
            3'h4: tap_divisor = 13'h0200;
            3'h5: tap_divisor = 13'h0400;
            3'h6: tap_divisor = 13'h0800;
            default: tap_divisor = 13'h1000;
        endcase
    endfunction

endpackage

// *** test/glass_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Passive glass: it draws no answer from the block, it only measures
// the clock, frame and drive windows that reach its pins.
module glass_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic glass_clk,
    input wire logic frame_start,
    input wire logic driver_on,
    output logic [31:0] ps_period,
    output logic [31:0] fr_period,
    output logic [31:0] on_len,
    output logic [31:0] ps_cnt,
    output logic [31:0] fr_cnt
);
    logic glass_q;
    logic [31:0] ps_t;
    logic [31:0] fr_t;
    logic [31:0] on_t;

    always_ff @(posedge mclk) begin
        if (rst) begin
            glass_q <= 1'b0;
            ps_t <= 32'h0000_0000;
            ps_period <= 32'h0000_0000;
            ps_cnt <= 32'h0000_0000;
        end else begin
            glass_q <= glass_clk;
            ps_t <= ps_t + 32'h0000_0001;
            if (glass_clk && !glass_q) begin
                ps_period <= ps_t;
                ps_t <= 32'h0000_0001;
                ps_cnt <= ps_cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fr_t <= 32'h0000_0000;
            fr_period <= 32'h0000_0000;
            fr_cnt <= 32'h0000_0000;
        end else begin
            fr_t <= fr_t + 32'h0000_0001;
            if (frame_start) begin
                fr_period <= fr_t;
                fr_t <= 32'h0000_0001;
                fr_cnt <= fr_cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            on_t <= 32'h0000_0000;
            on_len <= 32'h0000_0000;
        end else if (driver_on) begin
            on_t <= on_t + 32'h0000_0001;
        end else if (on_t != 32'h0000_0000) begin
            on_len <= on_t;
            on_t <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// *** test/test_lcd_frame_timing.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_lcd_frame_timing;
    import lcd_timing_pkg::*;

    typedef struct packed {
        logic [2:0] tap;
        logic [2:0] dv;
        logic [1:0] duty;
        logic [2:0] drv;
        logic [15:0] ps;
        logic [15:0] fr;
        logic [15:0] on;
    } row_t;

    logic mclk;
    logic rst;
    logic ext_clk;
    apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic glass_clk;
    logic frame_start;
    logic driver_on;
    logic blank_act;
    logic [31:0] ps_period;
    logic [31:0] fr_period;
    logic [31:0] on_len;
    logic [31:0] ps_cnt;
    logic [31:0] fr_cnt;
    logic [31:0] rd;
    logic err;
    logic [31:0] f;
    int n_fail;
    int total_checks;
    int r;

    // Nominal times are scaled to one cycle per microsecond; a zero frame
    // figure skips the frame measurement where it would run too long.
    row_t rows [10] = '{
        '{3'h0, 3'h0, 2'h3, 3'h1, 16'h0010, 16'h0080, 16'h0008},
        '{3'h1, 3'h1, 2'h2, 3'h1, 16'h0080, 16'h0300, 16'h0040},
        '{3'h2, 3'h2, 2'h1, 3'h2, 16'h0180, 16'h0C00, 16'h0096},
        '{3'h3, 3'h0, 2'h3, 3'h0, 16'h0100, 16'h0800, 16'h0080},
        '{3'h4, 3'h2, 2'h2, 3'h4, 16'h0600, 16'h0000, 16'h023F},
        '{3'h5, 3'h1, 2'h3, 3'h5, 16'h0800, 16'h0000, 16'h0352},
        '{3'h6, 3'h0, 2'h1, 3'h6, 16'h0800, 16'h0000, 16'h0400},
        '{3'h7, 3'h0, 2'h0, 3'h3, 16'h1000, 16'h0000, 16'h0800},
        '{3'h0, 3'h1, 2'h1, 3'h7, 16'h0020, 16'h0100, 16'h0010},
        '{3'h0, 3'h7, 2'h0, 3'h0, 16'h0080, 16'h0400, 16'h0040}
    };

    lcd_frame_timing #(.CYCLES_PER_US_P(1)) u_lcd_frame_timing (
        .mclk(mclk),
        .rst(rst),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ext_clk(ext_clk),
        .prescaled_glass_clock(glass_clk),
        .frame_start(frame_start),
        .driver_on(driver_on),
        .display_blank_active(blank_act)
    );

    glass_model u_glass_model (
        .mclk(mclk),
        .rst(rst),
        .glass_clk(glass_clk),
        .frame_start(frame_start),
        .driver_on(driver_on),
        .ps_period(ps_period),
        .fr_period(fr_period),
        .on_len(on_len),
        .ps_cnt(ps_cnt),
        .fr_cnt(fr_cnt)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // The external source runs free at a rate unrelated to mclk.
    initial begin
        ext_clk = 1'b0;
        forever #515 ext_clk = ~ext_clk;
    end

    task automatic final_report;
        $display("Checks %0d, failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        req <= '0;
        if (i == 16) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic wait_ev(input logic fr, input logic [31:0] n);
        logic [31:0] s;
        int i;
        s = fr ? fr_cnt : ps_cnt;
        for (i = 0; i < 40000; i++) begin
            @(posedge mclk);
            if ((fr ? fr_cnt : ps_cnt) - s >= n) break;
        end
        if (i == 40000) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic cfg(input logic [2:0] tap, input logic [2:0] dv,
                       input logic [1:0] duty, input logic [2:0] drv,
                       input logic src);
        apb(1'b1, OFS_FRAME_RATE, {24'h00_0000, 1'b0, tap, 1'b0, dv});
        apb(1'b1, OFS_CONTRAST_DRIVE, {24'h00_0000, drv, 5'h00});
        apb(1'b1, OFS_GLASS_CTRL_B, {24'h00_0000, src, 1'b0, duty, 4'h0});
    endtask

    initial begin
        n_fail = 0;
        total_checks = 0;
        rst = 1'b1;
        req = '0;
        repeat (6) @(posedge mclk);
        chk({28'h000_0000, glass_clk, frame_start, driver_on, blank_act},
            32'h0000_0000);
        rst <= 1'b0;
        for (r = 0; r < 4; r++) begin
            apb(1'b0, 8'(r * 4), 32'h0000_0000);
            chk(rd, {24'h00_0000, REG_RESET});
        end
        for (r = 0; r < 10; r++) begin
            cfg(rows[r].tap, rows[r].dv, rows[r].duty, rows[r].drv, 1'b0);
            wait_ev(1'b0, 32'h0000_0003);
            chk(ps_period, 32'(rows[r].ps));
            chk(on_len, 32'(rows[r].on));
            if (rows[r].fr != 16'h0000) begin
                wait_ev(1'b1, 32'h0000_0003);
                chk(fr_period, 32'(rows[r].fr));
            end
        end
        apb(1'b1, OFS_FRAME_RATE, 32'hFFFF_FFFF);
        apb(1'b0, OFS_FRAME_RATE, 32'h0000_0000);
        chk(rd, 32'h0000_0077);
        apb(1'b1, OFS_CONTRAST_DRIVE, 32'hFFFF_FFFF);
        apb(1'b0, OFS_CONTRAST_DRIVE, 32'h0000_0000);
        chk(rd, 32'h0000_00EF);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        // A drive change just after a frame start shows within the frame.
        cfg(3'h3, 3'h0, 2'h3, 3'h1, 1'b0);
        wait_ev(1'b1, 32'h0000_0002);
        chk(on_len, 32'h0000_0046);
        apb(1'b1, OFS_CONTRAST_DRIVE, 32'h0000_0040);
        f = fr_cnt;
        wait_ev(1'b0, 32'h0000_0002);
        chk(on_len, 32'h0000_0080);
        chk(fr_cnt, f);
        // Software blanks, waits for a frame start, then changes drive time.
        apb(1'b1, OFS_GLASS_CTRL_A, 32'h0000_0001);
        chk({31'h0000_0000, blank_act}, 32'h0000_0000);
        wait_ev(1'b1, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk({31'h0000_0000, blank_act}, 32'h0000_0001);
        apb(1'b1, OFS_CONTRAST_DRIVE, 32'h0000_0020);
        wait_ev(1'b0, 32'h0000_0003);
        chk(on_len, 32'h0000_0080);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(32'(rd[ST_BLANK_BIT]), 32'h0000_0001);
        apb(1'b1, OFS_GLASS_CTRL_A, 32'h0000_0000);
        // Sixteen external periods of 1030 ns land on 164 or 165 cycles.
        cfg(3'h0, 3'h0, 2'h3, 3'h1, 1'b1);
        wait_ev(1'b0, 32'h0000_0003);
        total_checks++;
        if (ps_period < 32'h0000_00A4 ||
            ps_period > 32'h0000_00A5) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, ps_period,
                     32'h0000_00A4);
        end
        final_report();
    end
endmodule
`default_nettype wire
